//--- psc_pkg.sv
`default_nettype none
package psc_pkg;

   // Clock period of the supervisory logic, 25 MHz.
   localparam int CLK_NS = 40;

   // Default timing figures in nanoseconds; the top module exposes them as parameters.
   localparam int OC_RESP_DELAY_NS = 80;
   localparam int DISC_WINDOW_NS = 40;
   localparam int SC_RESET_HOLD_NS = 20000;

   // Positive-going switch command frequency threshold, in kHz.
   localparam int FREQ_THRESH_KHZ = 1000;
   localparam int NS_PER_KHZ_PERIOD = 1000000;

   // Consecutive fast command cycles needed before the high converter limit is taken.
   localparam int FAST_CYCLES_NEEDED = 5;

   // Width of the timing counters.
   localparam int CNT_W = 16;

   // Synchroniser lane positions.
   localparam int LN_CMD = 0;
   localparam int LN_OC = 1;
   localparam int LN_SC = 2;
   localparam int LN_BB_START = 3;
   localparam int LN_PK_LOW = 4;
   localparam int LN_PK_HIGH = 5;
   localparam int LN_IND_ZERO = 6;
   localparam int LN_COUNT = 7;

   typedef enum logic [2:0]
   {
      PSC_IDLE = 3'h0,
      PSC_ARMED = 3'h1,
      PSC_OC_WAIT = 3'h3,
      PSC_OC_TRIP = 3'h2,
      PSC_SHORT = 3'h6
   } psc_prot_e;

   typedef enum logic [1:0]
   {
      PSC_BB_IDLE = 2'h0,
      PSC_BB_ENERGIZE = 2'h1,
      PSC_BB_RELEASE = 2'h3
   } psc_bb_e;

   // Gate driver commands.
   typedef struct packed
   {
      logic gate_on;
      logic soft_off;
   } psc_drive_s;

   // Fault report pins, both active low.
   typedef struct packed
   {
      logic overcurrent_flag_n;
      logic fault_n;
   } psc_report_s;

   // Least time rounded up to whole cycles, never below one.
   function automatic int cyc_ceil(input int ns);
      int c;
      c = (ns + CLK_NS - 1) / CLK_NS;
      return (c < 1) ? 1 : c;
   endfunction : cyc_ceil

   // Longest time rounded down to whole cycles, never below one.
   function automatic int cyc_floor(input int ns);
      int c;
      c = ns / CLK_NS;
      return (c < 1) ? 1 : c;
   endfunction : cyc_floor

endpackage : psc_pkg
`default_nettype wire

//--- psc_sync.sv
`timescale 1ns/1ps
`default_nettype none
module psc_sync #(
   parameter int W = 1
) (
   input wire logic clock, // System clock.
   input wire logic rstn, // Asynchronous reset, active low.
   input wire logic [W-1:0] async_in, // Levels from outside the clock domain.
   output logic [W-1:0] sync_out // Levels after two flip-flops.
);

   logic [W-1:0] meta_r;
   logic [W-1:0] meta_nxt;
   logic [W-1:0] sync_nxt;

   always_comb
   begin
      meta_nxt = async_in;
      sync_nxt = meta_r;
   end

   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         meta_r <= '0;
         sync_out <= '0;
      end
      else
      begin
         meta_r <= meta_nxt;
         sync_out <= sync_nxt;
      end
   end

endmodule : psc_sync
`default_nettype wire

//--- psc_freq_sel.sv
`timescale 1ns/1ps
`default_nettype none
module psc_freq_sel #(
   parameter int CNT_W = psc_pkg::CNT_W,
   parameter int THRESH_KHZ = psc_pkg::FREQ_THRESH_KHZ,
   parameter int NEEDED = psc_pkg::FAST_CYCLES_NEEDED
) (
   input wire logic clock, // System clock.
   input wire logic rstn, // Asynchronous reset, active low.
   input wire logic cmd_rise, // One-cycle pulse on each switch command rising edge.
   output logic high_sel // Sticky selection of the high converter peak limit.
);

   // A period of at most this many cycles counts as above the threshold frequency.
   localparam logic [CNT_W-1:0] PERIOD_CYC =
      CNT_W'(psc_pkg::cyc_floor(psc_pkg::NS_PER_KHZ_PERIOD / THRESH_KHZ));
   localparam logic [CNT_W-1:0] CNT_MAX = '1;
   localparam logic [3:0] STREAK_DONE = 4'(NEEDED);

   logic [CNT_W-1:0] period_r, period_nxt;
   logic [3:0] streak_r, streak_nxt;
   logic seen_r, seen_nxt;
   logic high_nxt;

   always_comb
   begin
      period_nxt = (period_r == CNT_MAX) ? period_r : period_r + 1'b1;
      streak_nxt = streak_r;
      seen_nxt = seen_r;
      high_nxt = high_sel;
      if (cmd_rise)
      begin
         period_nxt = '0;
         seen_nxt = 1'b1;
         if (seen_r && (period_r < PERIOD_CYC))
         begin
            streak_nxt = streak_r + 4'h1; // [RQ10]
            if (streak_r + 4'h1 >= STREAK_DONE)
               high_nxt = 1'b1; // [RQ12]
         end
         else
            streak_nxt = 4'h0; // [RQ12]
      end
   end

   // Nothing but reset clears the high selection. [RQ13]
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         period_r <= '0;
         streak_r <= 4'h0;
         seen_r <= 1'b0;
         high_sel <= 1'b0; // [RQ11]
      end
      else
      begin
         period_r <= period_nxt;
         streak_r <= streak_nxt;
         seen_r <= seen_nxt;
         high_sel <= high_nxt;
      end
   end

endmodule : psc_freq_sel
`default_nettype wire

//--- psc_protect.sv
// Notes on behaviour
// [RQ1] Overcurrent turns switch off and lowers flag after the response delay.
// [RQ2] Switch command going low clears overcurrent flag and shutoff.
// [RQ3] After overcurrent clears, the next command rising edge turns the switch on.
// [RQ4] Overcurrent detection is delayed by a window and raced against short detection.
// [RQ5] Delayed overcurrent arriving first means plain overcurrent, cycle by cycle.
// [RQ6] Short detection arriving first means a short-circuit fault.
// [RQ7] A short-circuit fault turns the switch off with reduced drive strength.
// [RQ8] Short fault latches off until command held low long enough, or power loss.
// [RQ9] Converter inductor energizes from cycle start until active peak limit reached.
// [RQ10] Converter limit chosen by comparing command frequency with a fixed threshold.
// [RQ11] Converter starts with the low peak limit after power-up.
// [RQ12] High limit only after five consecutive command cycles above threshold.
// [RQ13] High limit, once chosen, stays until power is removed.
// [RQ14] Overcurrent flag goes low for overcurrent and short faults, high otherwise.
// [RQ15] Fault output low during short fault until latch reset, high on overcurrent.
// [RQ16] Response delay, window and reset hold time are parameters.
`timescale 1ns/1ps
`default_nettype none
module psc_protect #(
   parameter int OC_RESP_DELAY_NS = psc_pkg::OC_RESP_DELAY_NS, // [RQ16]
   parameter int DISC_WINDOW_NS = psc_pkg::DISC_WINDOW_NS, // [RQ16]
   parameter int SC_RESET_HOLD_NS = psc_pkg::SC_RESET_HOLD_NS, // [RQ16]
   parameter int FREQ_THRESH_KHZ = psc_pkg::FREQ_THRESH_KHZ,
   parameter int CNT_W = psc_pkg::CNT_W
) (
   input wire logic clock, // System clock, 25 MHz.
   input wire logic rstn, // Asynchronous reset, active low; bias power good.
   input wire logic switch_cmd, // Switch command from the controller, high means on.
   input wire logic oc_detect, // Drain current above the overcurrent limit.
   input wire logic sc_detect, // Drain current above the higher short threshold.
   input wire logic bb_start, // Converter controller requests a new current pulse.
   input wire logic peak_low_hit, // Inductor current reached the low peak limit.
   input wire logic peak_high_hit, // Inductor current reached the high peak limit.
   input wire logic ind_zero, // Inductor current has fallen to zero.
   output var psc_pkg::psc_drive_s drive, // Gate on and reduced-strength turn-off command.
   output var psc_pkg::psc_report_s report, // Active-low overcurrent and fault pins.
   output logic bb_energize, // Converter switch on, inductor energizing.
   output logic peak_high_sel // High converter peak limit selected.
);

   localparam logic [CNT_W-1:0] RESP_CYC = CNT_W'(psc_pkg::cyc_ceil(OC_RESP_DELAY_NS));
   localparam logic [CNT_W-1:0] WINDOW_CYC = CNT_W'(psc_pkg::cyc_ceil(DISC_WINDOW_NS));
   localparam logic [CNT_W-1:0] HOLD_CYC = CNT_W'(psc_pkg::cyc_ceil(SC_RESET_HOLD_NS));
   localparam logic [CNT_W-1:0] CNT_MAX = '1;

   logic [psc_pkg::LN_COUNT-1:0] pins_raw;
   logic [psc_pkg::LN_COUNT-1:0] pins;
   logic cmd, oc, sc;
   logic cmd_d_r, cmd_d_nxt;
   logic cmd_rise;
   logic high_sel;

   assign pins_raw = {ind_zero, peak_high_hit, peak_low_hit, bb_start, sc_detect, oc_detect, switch_cmd};

   // Every comparator and the command come from outside the clock domain.
   psc_sync #(
      .W(psc_pkg::LN_COUNT)
   ) u_sync (
      .clock(clock),
      .rstn(rstn),
      .async_in(pins_raw),
      .sync_out(pins)
   );

   assign cmd = pins[psc_pkg::LN_CMD];
   assign oc = pins[psc_pkg::LN_OC];
   assign sc = pins[psc_pkg::LN_SC];
   assign cmd_rise = cmd && !cmd_d_r;

   psc_freq_sel #(
      .CNT_W(CNT_W),
      .THRESH_KHZ(FREQ_THRESH_KHZ),
      .NEEDED(psc_pkg::FAST_CYCLES_NEEDED)
   ) u_freq (
      .clock(clock),
      .rstn(rstn),
      .cmd_rise(cmd_rise),
      .high_sel(high_sel)
   );

   // Protection state.
   psc_pkg::psc_prot_e st_r, st_nxt;
   logic [CNT_W-1:0] cnt_r, cnt_nxt;
   psc_pkg::psc_drive_s drive_nxt;
   psc_pkg::psc_report_s report_nxt;

   function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] v);
      return (v == CNT_MAX) ? v : v + 1'b1;
   endfunction : sat_inc

   always_comb
   begin
      st_nxt = st_r;
      cnt_nxt = sat_inc(cnt_r);
      cmd_d_nxt = cmd;
      unique case (st_r)
         psc_pkg::PSC_IDLE:
         begin
            cnt_nxt = '0;
            if (sc)
               st_nxt = psc_pkg::PSC_SHORT; // [RQ6]
            else if (oc)
               st_nxt = psc_pkg::PSC_ARMED; // [RQ4]
         end
         psc_pkg::PSC_ARMED:
         begin
            // Race: the short comparator wins unless the delayed overcurrent matured first.
            if (sc)
            begin
               st_nxt = psc_pkg::PSC_SHORT; // [RQ6]
               cnt_nxt = '0;
            end
            else if (!oc || !cmd)
               st_nxt = psc_pkg::PSC_IDLE;
            else if (cnt_r + 1'b1 >= WINDOW_CYC)
               st_nxt = psc_pkg::PSC_OC_WAIT; // [RQ4] [RQ5]
         end
         psc_pkg::PSC_OC_WAIT:
         begin
            if (!cmd)
               st_nxt = psc_pkg::PSC_IDLE; // [RQ2]
            else if (cnt_r + 1'b1 >= RESP_CYC)
               st_nxt = psc_pkg::PSC_OC_TRIP; // [RQ1]
         end
         psc_pkg::PSC_OC_TRIP:
         begin
            // Not latched: the command's low phase ends the trip.
            if (!cmd)
               st_nxt = psc_pkg::PSC_IDLE; // [RQ2]
         end
         psc_pkg::PSC_SHORT:
         begin
            // Any high command restarts the hold, so a glitchy command cannot clear it.
            if (cmd)
               cnt_nxt = '0; // [RQ8]
            else if (cnt_r + 1'b1 >= HOLD_CYC)
               st_nxt = psc_pkg::PSC_IDLE; // [RQ8]
         end
         default:
         begin
            st_nxt = psc_pkg::PSC_SHORT;
            cnt_nxt = '0;
         end
      endcase

      // Gate follows the command except while tripped or latched. [RQ3]
      drive_nxt.gate_on = cmd && (st_nxt != psc_pkg::PSC_OC_TRIP) && (st_nxt != psc_pkg::PSC_SHORT);
      drive_nxt.soft_off = (st_nxt == psc_pkg::PSC_SHORT); // [RQ7]
      report_nxt.overcurrent_flag_n =
         !((st_nxt == psc_pkg::PSC_OC_TRIP) || (st_nxt == psc_pkg::PSC_SHORT)); // [RQ1] [RQ14]
      report_nxt.fault_n = (st_nxt != psc_pkg::PSC_SHORT); // [RQ15]
   end

   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         st_r <= psc_pkg::PSC_IDLE;
         cnt_r <= '0;
         cmd_d_r <= 1'b0;
         drive <= '0;
         report <= '1;
      end
      else
      begin
         st_r <= st_nxt;
         cnt_r <= cnt_nxt;
         cmd_d_r <= cmd_d_nxt;
         drive <= drive_nxt;
         report <= report_nxt;
      end
   end

   // Negative-rail converter pulse control.
   psc_pkg::psc_bb_e bb_r, bb_nxt;
   logic bb_energize_nxt;
   logic peak_hit;

   // The active limit comparator ends the energizing phase. [RQ9]
   assign peak_hit = high_sel ? pins[psc_pkg::LN_PK_HIGH] : pins[psc_pkg::LN_PK_LOW];

   always_comb
   begin
      bb_nxt = bb_r;
      unique case (bb_r)
         psc_pkg::PSC_BB_IDLE:
            if (pins[psc_pkg::LN_BB_START])
               bb_nxt = psc_pkg::PSC_BB_ENERGIZE; // [RQ9]
         psc_pkg::PSC_BB_ENERGIZE:
            if (peak_hit)
               bb_nxt = psc_pkg::PSC_BB_RELEASE; // [RQ9]
         psc_pkg::PSC_BB_RELEASE:
            // Wait for zero current so the converter stays discontinuous.
            if (pins[psc_pkg::LN_IND_ZERO])
               bb_nxt = psc_pkg::PSC_BB_IDLE;
         default:
            bb_nxt = psc_pkg::PSC_BB_IDLE;
      endcase
      bb_energize_nxt = (bb_nxt == psc_pkg::PSC_BB_ENERGIZE);
   end

   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         bb_r <= psc_pkg::PSC_BB_IDLE;
         bb_energize <= 1'b0;
         peak_high_sel <= 1'b0; // [RQ11]
      end
      else
      begin
         bb_r <= bb_nxt;
         bb_energize <= bb_energize_nxt;
         peak_high_sel <= high_sel; // [RQ13]
      end
   end

endmodule : psc_protect
`default_nettype wire

//--- psc_protect_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module psc_protect_monitor #(
   parameter int SC_RESET_HOLD_NS = psc_pkg::SC_RESET_HOLD_NS
) (
   input wire logic clock, // Clock.
   input wire logic rstn, // Reset, active low.
   input wire logic switch_cmd, // Switch command.
   input wire logic oc_detect, // Overcurrent detect.
   input wire logic sc_detect, // Short detect.
   input wire logic bb_start, // Pulse request.
   input wire logic peak_low_hit, // Low peak reached.
   input wire logic peak_high_hit, // High peak reached.
   input wire logic ind_zero, // Inductor empty.
   input wire psc_pkg::psc_drive_s drive, // Gate commands.
   input wire psc_pkg::psc_report_s report, // Report pins.
   input wire logic bb_energize, // Converter switch on.
   input wire logic peak_high_sel // High limit chosen.
);
   localparam int HOLD_CYC = psc_pkg::cyc_ceil(SC_RESET_HOLD_NS);
   logic [15:0] low_cnt_r;
   logic [15:0] low_cnt_nxt;
   always_comb
   begin
      low_cnt_nxt = low_cnt_r;
      if (switch_cmd)
         low_cnt_nxt = 16'h0;
      else if (low_cnt_r != 16'hFFFF)
         low_cnt_nxt = low_cnt_r + 16'h1;
   end
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
         low_cnt_r <= 16'h0;
      else
         low_cnt_r <= low_cnt_nxt;
   end
   default clocking @(posedge clock); endclocking
   default disable iff (!rstn);
   // The pin lags the inputs by the two synchroniser flops plus the output flop.
   sequence s_oc_held;
      (oc_detect && switch_cmd && !sc_detect) [*8];
   endsequence
   sequence s_trip_cmd_low;
      (!report.overcurrent_flag_n && !drive.soft_off && !switch_cmd) [*3];
   endsequence
   a_oc_trip_flag: assert property (s_oc_held |-> !report.overcurrent_flag_n)
      else $error("overcurrent held but flag not low");
   a_oc_cmd_clear: assert property (s_trip_cmd_low |=> report.overcurrent_flag_n)
      else $error("overcurrent flag not cleared by command low");
   a_short_all_off: assert property (drive.soft_off |-> !drive.gate_on && !report.fault_n
      && !report.overcurrent_flag_n)
      else $error("short state outputs wrong");
   a_fault_only_short: assert property (!report.fault_n |-> drive.soft_off)
      else $error("fault low without short latch");
   a_short_needs_sc: assert property ($fell(report.fault_n) |-> $past(sc_detect, 3)
      || $past(sc_detect, 4))
      else $error("short reported without short detection");
   a_short_hold_time: assert property ($fell(drive.soft_off) |-> int'(low_cnt_r) >= HOLD_CYC)
      else $error("short latch released early");
   a_gate_needs_cmd: assert property (drive.gate_on |-> $past(switch_cmd, 3))
      else $error("gate on without command");
   a_energize_start: assert property ($rose(bb_energize) |-> $past(bb_start, 3))
      else $error("energize without pulse request");
   a_energize_low_end: assert property ((peak_low_hit && !peak_high_sel && !bb_start) [*4]
      |-> !bb_energize)
      else $error("energize not ended at low peak");
   a_high_sel_sticky: assert property (peak_high_sel |=> peak_high_sel)
      else $error("high limit dropped");
endmodule : psc_protect_monitor
bind psc_protect psc_protect_monitor #(.SC_RESET_HOLD_NS(SC_RESET_HOLD_NS)) mon (
   .clock(clock), .rstn(rstn), .switch_cmd(switch_cmd), .oc_detect(oc_detect),
   .sc_detect(sc_detect), .bb_start(bb_start), .peak_low_hit(peak_low_hit),
   .peak_high_hit(peak_high_hit), .ind_zero(ind_zero), .drive(drive), .report(report),
   .bb_energize(bb_energize), .peak_high_sel(peak_high_sel));
`default_nettype wire

//--- psc_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
module psc_ctrl_model (
   input wire logic clock, // Clock.
   output logic switch_cmd // Switch command to the block.
);
   initial switch_cmd = 1'b0;
   // Holds the command for n cycles; a long low hold is how the controller clears a short latch.
   task automatic level(input logic v, input int n);
      switch_cmd <= v;
      repeat (n) @(posedge clock);
   endtask : level
   task automatic burst(input int n, input int p);
      repeat (n)
      begin
         level(1'b1, p / 2);
         level(1'b0, p - p / 2);
      end
   endtask : burst
endmodule : psc_ctrl_model
`default_nettype wire

//--- power_switch_current_protection_bench.sv
`timescale 1ns/1ps
`default_nettype none
module power_switch_current_protection_bench;
   logic clock;
   logic rstn;
   logic switch_cmd;
   logic oc_detect;
   logic sc_detect;
   logic bb_start;
   logic peak_low_hit;
   logic peak_high_hit;
   logic ind_zero;
   psc_pkg::psc_drive_s drive;
   psc_pkg::psc_report_s report;
   logic bb_energize;
   logic peak_high_sel;
   int errors = 0;
   int tests_run = 0;
   // A short hold of 10 cycles keeps the latch release quick to reach.
   psc_protect #(.SC_RESET_HOLD_NS(400)) uut (
      .clock(clock), .rstn(rstn), .switch_cmd(switch_cmd), .oc_detect(oc_detect),
      .sc_detect(sc_detect), .bb_start(bb_start), .peak_low_hit(peak_low_hit),
      .peak_high_hit(peak_high_hit), .ind_zero(ind_zero), .drive(drive), .report(report),
      .bb_energize(bb_energize), .peak_high_sel(peak_high_sel));
   psc_ctrl_model ctl (.clock(clock), .switch_cmd(switch_cmd));
   initial
   begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end
   task automatic check(input string what, input logic seen, input logic exp);
      tests_run++;
      if (seen !== exp)
      begin
         errors++;
         $display("wrong value %s expected %b seen %b", what, exp, seen);
      end
   endtask : check
   task automatic end_of_test;
      $display("checks %0d errors %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : end_of_test
   function automatic logic pick(input int s);
      case (s)
         0: return report.overcurrent_flag_n;
         1: return drive.soft_off;
         2: return bb_energize;
         default: return drive.gate_on;
      endcase
   endfunction : pick
   task automatic wait_for(input int s, input logic v);
      int n;
      n = 0;
      while (pick(s) !== v)
      begin
         @(posedge clock);
         n++;
         if (n > 40)
         begin
            errors++;
            $display("wrong value wait %0d expected %b seen %b", s, v, pick(s));
            end_of_test();
         end
      end
   endtask : wait_for
   task automatic t_oc;
      ctl.level(1'b1, 6);
      check("gate", drive.gate_on, 1'b1);
      oc_detect <= 1'b1;
      repeat (3) @(posedge clock);
      check("flag early", report.overcurrent_flag_n, 1'b1);
      wait_for(0, 1'b0);
      check("gate tripped", drive.gate_on, 1'b0);
      repeat (4) @(posedge clock);
      check("fault on oc", report.fault_n, 1'b1);
      oc_detect <= 1'b0;
      ctl.level(1'b0, 1);
      wait_for(0, 1'b1);
      ctl.level(1'b1, 1);
      wait_for(3, 1'b1);
   endtask : t_oc
   task automatic t_race;
      oc_detect <= 1'b1;
      repeat (4) @(posedge clock);
      sc_detect <= 1'b1;
      wait_for(0, 1'b0);
      repeat (4) @(posedge clock);
      check("late short fault", report.fault_n, 1'b1);
      check("late short soft", drive.soft_off, 1'b0);
      oc_detect <= 1'b0;
      sc_detect <= 1'b0;
      repeat (4) @(posedge clock);
      ctl.level(1'b0, 1);
      wait_for(0, 1'b1);
   endtask : t_race
   task automatic t_short;
      ctl.level(1'b1, 6);
      oc_detect <= 1'b1;
      sc_detect <= 1'b1;
      wait_for(1, 1'b1);
      check("short fault", report.fault_n, 1'b0);
      check("short flag", report.overcurrent_flag_n, 1'b0);
      check("short gate", drive.gate_on, 1'b0);
      oc_detect <= 1'b0;
      sc_detect <= 1'b0;
      ctl.level(1'b0, 6);
      ctl.level(1'b1, 4);
      check("short gate held", drive.gate_on, 1'b0);
      ctl.level(1'b0, 8);
      check("short latched", drive.soft_off, 1'b1);
      ctl.level(1'b0, 6);
      wait_for(1, 1'b0);
      check("fault cleared", report.fault_n, 1'b1);
      ctl.level(1'b1, 1);
      wait_for(3, 1'b1);
      ctl.level(1'b0, 4);
   endtask : t_short
   task automatic t_conv(input logic high);
      bb_start <= 1'b1;
      wait_for(2, 1'b1);
      bb_start <= 1'b0;
      if (high)
         peak_low_hit <= 1'b1;
      else
         peak_high_hit <= 1'b1;
      repeat (6) @(posedge clock);
      check("wrong limit ignored", bb_energize, 1'b1);
      peak_low_hit <= 1'b1;
      peak_high_hit <= 1'b1;
      wait_for(2, 1'b0);
      peak_low_hit <= 1'b0;
      peak_high_hit <= 1'b0;
      ind_zero <= 1'b1;
      repeat (4) @(posedge clock);
      ind_zero <= 1'b0;
   endtask : t_conv
   task automatic t_freq;
      ctl.burst(6, 40);
      check("slow sel", peak_high_sel, 1'b0);
      ctl.level(1'b0, 30);
      ctl.burst(5, 10);
      ctl.level(1'b0, 4);
      check("four fast", peak_high_sel, 1'b0);
      ctl.level(1'b0, 30);
      ctl.burst(6, 10);
      ctl.level(1'b0, 4);
      check("five fast", peak_high_sel, 1'b1);
      ctl.burst(6, 40);
      check("stays high", peak_high_sel, 1'b1);
   endtask : t_freq
   // Removing bias power is the other way out of a short latch, and it also drops the high limit.
   task automatic t_power;
      ctl.level(1'b1, 2);
      sc_detect <= 1'b1;
      wait_for(1, 1'b1);
      sc_detect <= 1'b0;
      ctl.level(1'b0, 2);
      rstn <= 1'b0;
      repeat (6) @(posedge clock);
      rstn <= 1'b1;
      check("power latch", drive.soft_off, 1'b0);
      @(posedge clock);
      check("power fault", report.fault_n, 1'b1);
      check("power sel", peak_high_sel, 1'b0);
      ctl.level(1'b1, 4);
      check("power gate", drive.gate_on, 1'b1);
   endtask : t_power
   initial
   begin
      rstn = 1'b0;
      oc_detect = 1'b0;
      sc_detect = 1'b0;
      bb_start = 1'b0;
      peak_low_hit = 1'b0;
      peak_high_hit = 1'b0;
      ind_zero = 1'b0;
      repeat (6) @(posedge clock);
      rstn <= 1'b1;
      @(posedge clock);
      check("reset flag", report.overcurrent_flag_n, 1'b1);
      check("reset fault", report.fault_n, 1'b1);
      check("reset sel", peak_high_sel, 1'b0);
      t_oc();
      t_race();
      t_short();
      t_conv(1'b0);
      t_freq();
      t_conv(1'b1);
      t_power();
      end_of_test();
   end
endmodule : power_switch_current_protection_bench
`default_nettype wire
